// *** hdl/beat_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module beat_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    // Filling side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Draining side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = $clog2(D);

    logic [W-1:0]  store [0:D-1];    // Word storage
    logic [PW-1:0] wr_ptr;           // Next slot to fill
    logic [PW-1:0] rd_ptr;           // Oldest slot
    logic [PW:0]   count;            // Words held
    logic          push;
    logic          pop;

    assign in_ready_o  = (count != D[PW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o  = store[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointers and occupancy
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end

    // Storage write
    always_ff @(posedge mclk_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

endmodule
`default_nettype wire

// *** hdl/sdram_access_pkg.sv ***
`default_nettype none
package sdram_access_pkg;

    // Array geometry
    localparam int COL_W       = 9;        // Column address width
    localparam int ROW_W       = 12;       // Row address width
    localparam int BANK_W      = 2;        // Bank select width
    localparam int DATA_W      = 16;       // Data pins
    localparam int LANES       = 2;        // Byte lanes
    localparam int ROW_KEEP    = 2;        // Row bits that address storage
    localparam int MEM_AW      = BANK_W + ROW_KEEP + COL_W;
    localparam int MEM_WORDS   = 1 << MEM_AW;
    localparam int FIFO_DEPTH  = 4;        // Write queue depth
    localparam int LEN_W       = 10;       // Burst length counter width

    // Command codes on {row, column, write} strobes
    localparam logic [2:0] CMD_MODE = 3'h0;
    localparam logic [2:0] CMD_ACT  = 3'h3;
    localparam logic [2:0] CMD_RD   = 3'h5;
    localparam logic [2:0] CMD_WR   = 3'h4;
    localparam logic [2:0] CMD_STOP = 3'h6;
    localparam logic [2:0] CMD_PRE  = 3'h2;

    // Mode word fields and reset value
    localparam int BL_LSB      = 0;        // Burst length code, 3 bits
    localparam int BT_BIT      = 3;        // Burst type: 1 interleave
    localparam int CL_LSB      = 4;        // CAS latency, 3 bits
    localparam int WB_BIT      = 9;        // Single-word writes
    localparam int ALL_BIT     = 10;       // Precharge all banks
    localparam logic [11:0] MODE_RESET = 12'h020;
    localparam logic [2:0]  CL_THREE   = 3'h3;

    // Burst length codes
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;

    // Burst sequencer states
    typedef enum logic [1:0] {
        BURST_IDLE  = 2'b00,
        BURST_READ  = 2'b01,
        BURST_WRITE = 2'b10
    } burst_kind_t;

    // One queued write word
    typedef struct packed {
        logic [MEM_AW-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  be;
    } wr_beat_t;

    // Burst length in words from its code
    function automatic logic [LEN_W-1:0] len_of(input logic [2:0] code);
        case (code)
            BL_2:    len_of = 10'h002;
            BL_4:    len_of = 10'h004;
            BL_8:    len_of = 10'h008;
            BL_PAGE: len_of = 10'h200;
            default: len_of = 10'h001;
        endcase
    endfunction

endpackage
`default_nettype wire

// *** hdl/sdram_command_access.sv ***
// Behaviour
// - All strobes low loads mode from address
// - Row high, column low decodes column access
// - Accept column commands every clock cycle
// - Read burst follows mode type and length
// - Write words each edge; extra ignored
// - Read interrupting read restarts full burst
// - Old read data until new latency
// - Write interrupting write restarts full burst
// - Read ends write burst at once
// - Burst stop decode: row, column high
// - Stopped read floats pins after latency
// - Mask floats reads in two, blocks writes
// - Chip select high ignores new commands
// - Row twelve bits, column nine, four banks
`timescale 1ns/1ns
`default_nettype none
module sdram_command_access (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // Command pins
    input  wire logic        chip_select_n_i,
    input  wire logic        row_strobe_n_i,
    input  wire logic        column_strobe_n_i,
    input  wire logic        write_strobe_n_i,
    input  wire logic        clock_gate_i,
    // Address pins
    input  wire logic [11:0] addr_i,
    input  wire logic        bank_pick_lo_i,
    input  wire logic        bank_pick_hi_i,
    // Byte masks
    input  wire logic        low_byte_mask_i,
    input  wire logic        high_byte_mask_i,
    // Data pins
    input  wire logic [15:0] data_pins_i,
    output logic      [15:0] data_pins_o,
    output logic      [1:0]  data_pins_oe_n_o,
    // Status
    output logic      [3:0]  bank_open_o,
    output logic             write_stall_o
);

    // Column address of a burst word
    function automatic logic [8:0] col_of(
        input logic [8:0] base,
        input logic [9:0] idx,
        input logic [9:0] len,
        input logic       inter
    );
        logic [8:0] m;
        m = 9'(len - 10'h001);
        if (inter && (len != 10'h200)) begin
            col_of = base ^ (idx[8:0] & m);
        end else begin
            col_of = (base & ~m) | ((base + idx[8:0]) & m);
        end
    endfunction

    // Decoder
    logic        sel;              // Command decoder enabled
    logic [2:0]  strobes;          // {row, column, write}
    logic        is_mode;
    logic        is_act;
    logic        is_rd;
    logic        is_wr;
    logic        is_stop;
    logic        is_pre;
    logic [1:0]  cmd_bank;         // Bank named by the pins

    // Mode and bank state
    logic [11:0] mode_word;        // Loaded mode parameters
    logic [11:0] open_row [0:3];   // Row held open in each bank
    logic [3:0]  bank_open;        // Bank active flags

    // Burst sequencer
    sdram_access_pkg::burst_kind_t burst_kind;
    logic [8:0]  burst_base;       // Starting column
    logic [1:0]  burst_bank;       // Bank of the burst
    logic [9:0]  burst_idx;        // Next word index

    // Derived mode fields
    logic [9:0]  rd_len;
    logic [9:0]  wr_len;
    logic [9:0]  cur_len;
    logic        inter;
    logic        cl_three;

    // Current word
    logic        cont_beat;        // Burst continues this cycle
    logic        rd_beat;
    logic        wr_beat;
    logic [8:0]  beat_col;
    logic [1:0]  beat_bank;
    logic [12:0] beat_addr;
    logic [1:0]  wr_be;            // Byte lanes written

    // Read pipeline
    logic        rd_v0;
    logic        rd_v1;
    logic [15:0] rd_d0;
    logic [15:0] rd_d1;
    logic [15:0] rd_word;          // Array read value
    logic [1:0]  mask_d1;          // Masks one edge ago
    logic        next_v;
    logic [15:0] next_d;

    // Write queue
    sdram_access_pkg::wr_beat_t q_in;
    sdram_access_pkg::wr_beat_t q_out;
    logic        q_in_valid;
    logic        q_in_ready;
    logic        q_out_valid;
    logic        q_out_ready;

    // Command decode
    assign sel      = ~chip_select_n_i & clock_gate_i;
    assign strobes  = {row_strobe_n_i, column_strobe_n_i,
                       write_strobe_n_i};
    assign is_mode  = sel & (strobes == sdram_access_pkg::CMD_MODE);
    assign is_act   = sel & (strobes == sdram_access_pkg::CMD_ACT);
    assign is_rd    = sel & (strobes == sdram_access_pkg::CMD_RD);
    assign is_wr    = sel & (strobes == sdram_access_pkg::CMD_WR);
    assign is_stop  = sel & (strobes == sdram_access_pkg::CMD_STOP);
    assign is_pre   = sel & (strobes == sdram_access_pkg::CMD_PRE);
    assign cmd_bank = {bank_pick_hi_i, bank_pick_lo_i};

    // Mode fields in force until the next load
    assign rd_len   = sdram_access_pkg::len_of(
                          mode_word[sdram_access_pkg::BL_LSB +: 3]);
    assign wr_len   = mode_word[sdram_access_pkg::WB_BIT] ?
                      10'h001 : rd_len;
    assign inter    = mode_word[sdram_access_pkg::BT_BIT];
    assign cl_three = (mode_word[sdram_access_pkg::CL_LSB +: 3] ==
                       sdram_access_pkg::CL_THREE);
    assign cur_len  = (burst_kind == sdram_access_pkg::BURST_WRITE) ?
                      wr_len : rd_len;

    // Words after the first run until the length or a new read, write or burst stop
    assign cont_beat = (burst_kind != sdram_access_pkg::BURST_IDLE) &
                       (burst_idx < cur_len) &
                       ~is_rd & ~is_wr & ~is_stop;
    assign rd_beat   = is_rd | (cont_beat &
                       (burst_kind == sdram_access_pkg::BURST_READ));
    // A read in this cycle drops any write word on the pins
    assign wr_beat   = is_wr | (cont_beat &
                       (burst_kind == sdram_access_pkg::BURST_WRITE));
    assign beat_col  = (is_rd | is_wr) ? addr_i[8:0] :
                       col_of(burst_base, burst_idx, cur_len, inter);
    assign beat_bank = (is_rd | is_wr) ? cmd_bank : burst_bank;
    assign beat_addr = {beat_bank, open_row[beat_bank][1:0], beat_col};

    // Mask high blocks that lane's write in the same cycle
    assign wr_be      = ~{high_byte_mask_i, low_byte_mask_i};
    assign q_in       = '{addr: beat_addr, data: data_pins_i, be: wr_be};
    assign q_in_valid = wr_beat & (wr_be != 2'b00);
    // Reads own the array; queued writes wait for a free cycle
    assign q_out_ready = ~rd_beat;

    // Latency select for the output stage
    assign next_v = cl_three ? rd_v1 : rd_v0;
    assign next_d = cl_three ? rd_d1 : rd_d0;

    // Mode register load
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mode_word <= sdram_access_pkg::MODE_RESET;
        end else if (is_mode) begin
            mode_word <= addr_i;
        end
    end

    // Row open and close per bank
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bank_open <= 4'h0;
        end else if (is_act) begin
            bank_open[cmd_bank] <= 1'b1;
        end else if (is_pre) begin
            if (addr_i[sdram_access_pkg::ALL_BIT]) begin
                bank_open <= 4'h0;
            end else begin
                bank_open[cmd_bank] <= 1'b0;
            end
        end
    end

    // Row address latched at activate
    always_ff @(posedge mclk_i) begin
        if (is_act) begin
            open_row[cmd_bank] <= addr_i;
        end
    end

    // Burst sequencer
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            burst_kind <= sdram_access_pkg::BURST_IDLE;
            burst_base <= 9'h000;
            burst_bank <= 2'h0;
            burst_idx  <= 10'h000;
        end else if (is_rd | is_wr) begin
            // New command restarts a full burst at its column
            burst_kind <= is_rd ? sdram_access_pkg::BURST_READ :
                          sdram_access_pkg::BURST_WRITE;
            burst_base <= addr_i[8:0];
            burst_bank <= cmd_bank;
            burst_idx  <= 10'h001;
        end else if (is_stop) begin
            burst_kind <= sdram_access_pkg::BURST_IDLE;
        end else if (cont_beat) begin
            burst_idx  <= burst_idx + 10'h001;
        end else begin
            // Length reached: later pin data is ignored
            burst_kind <= sdram_access_pkg::BURST_IDLE;
        end
    end

    // Byte-lane storage arrays
    generate
        for (genvar g = 0; g < sdram_access_pkg::LANES; g++) begin : lane
            logic [7:0] mem [0:sdram_access_pkg::MEM_WORDS-1];
            assign rd_word[8*g +: 8] = mem[beat_addr];
            // Drain one queued word when reads leave the array free
            always_ff @(posedge mclk_i) begin
                if (q_out_valid & q_out_ready & q_out.be[g]) begin
                    mem[q_out.addr] <= q_out.data[8*g +: 8];
                end
            end
        end
    endgenerate

    // Read pipeline, old burst data drains ahead of new
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rd_v0   <= 1'b0;
            rd_v1   <= 1'b0;
            rd_d0   <= 16'h0000;
            rd_d1   <= 16'h0000;
            mask_d1 <= 2'h0;
        end else begin
            rd_v0   <= rd_beat;
            rd_d0   <= rd_word;
            rd_v1   <= rd_v0;
            rd_d1   <= rd_d0;
            mask_d1 <= {high_byte_mask_i, low_byte_mask_i};
        end
    end

    // Pin drivers: low enable drives, mask floats two edges later
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            data_pins_o      <= 16'h0000;
            data_pins_oe_n_o <= 2'b11;
        end else begin
            data_pins_o      <= next_d;
            data_pins_oe_n_o <= ~({2{next_v}} & ~mask_d1);
        end
    end

    // Status outputs
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bank_open_o   <= 4'h0;
            write_stall_o <= 1'b0;
        end else begin
            bank_open_o   <= bank_open;
            write_stall_o <= q_in_valid & ~q_in_ready;
        end
    end

    // Write queue between pins and array
    beat_fifo #(
        .W ($bits(sdram_access_pkg::wr_beat_t)),
        .D (sdram_access_pkg::FIFO_DEPTH)
    ) u_wr_queue (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (q_in_valid),
        .in_ready_o  (q_in_ready),
        .in_data_i   (q_in),
        .out_valid_o (q_out_valid),
        .out_ready_i (q_out_ready),
        .out_data_o  (q_out)
    );

endmodule
`default_nettype wire

// *** test/sdram_access_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module sdram_access_sva (
    // Clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    // Command and address pins
    input wire logic        chip_select_n_i,
    input wire logic        row_strobe_n_i,
    input wire logic        column_strobe_n_i,
    input wire logic        write_strobe_n_i,
    input wire logic        clock_gate_i,
    input wire logic [11:0] addr_i,
    input wire logic        bank_pick_lo_i,
    input wire logic        bank_pick_hi_i,
    input wire logic        low_byte_mask_i,
    input wire logic        high_byte_mask_i,
    // Watched outputs
    input wire logic [1:0]  data_pins_oe_n_o,
    input wire logic [3:0]  bank_open_o,
    input wire logic        write_stall_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [2:0] cmd;       // Strobe code
    logic       go;        // Command taken
    logic       rd;        // Read taken
    logic       md;        // Mode load taken
    logic       act;       // Activate taken
    logic       cl3;       // Latency three
    logic [9:0] blen;      // Burst words
    logic [9:0] next_blen; // Words from new mode
    logic [9:0] left;      // Read words still due
    logic       issue;     // Read word issued now
    assign cmd = {row_strobe_n_i, column_strobe_n_i, write_strobe_n_i};
    assign go  = !chip_select_n_i && clock_gate_i;
    assign rd  = go && cmd == sdram_access_pkg::CMD_RD;
    assign md  = go && cmd == sdram_access_pkg::CMD_MODE;
    assign act = go && cmd == sdram_access_pkg::CMD_ACT;
    assign issue = rd || (left != 10'h000 && !(go && (cmd ==
        sdram_access_pkg::CMD_WR || cmd == sdram_access_pkg::CMD_STOP)));
    assign next_blen = (addr_i[2:0] == 3'h7) ? 10'h200 :
        addr_i[2] ? 10'h001 : (10'h001 << addr_i[1:0]);
    // Mode copy and read word count
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cl3  <= 1'b0;
            blen <= 10'h001;
            left <= 10'h000;
        end else begin
            if (md) begin
                cl3  <= addr_i[6:4] == 3'h3;
                blen <= next_blen;
            end
            if (rd) left <= blen - 10'h001;
            else if (issue) left <= left - 10'h001;
            else left <= 10'h000;
        end
    end
    property p_idle_float;
        !issue |-> if (cl3) ##3 data_pins_oe_n_o == 2'h3
            else ##2 data_pins_oe_n_o == 2'h3;
    endproperty
    a_idle_float: assert property (p_idle_float)
        else $error("pins driven with no word due");
    property p_drive_cl2;
        issue && !cl3 && !low_byte_mask_i && !high_byte_mask_i
            |-> ##2 data_pins_oe_n_o == 2'h0;
    endproperty
    a_drive_cl2: assert property (p_drive_cl2)
        else $error("word missing at latency two");
    property p_drive_cl3;
        issue && cl3 |=> (low_byte_mask_i || high_byte_mask_i)
            or (##2 data_pins_oe_n_o == 2'h0);
    endproperty
    a_drive_cl3: assert property (p_drive_cl3)
        else $error("word missing at latency three");
    property p_lo_mask;
        low_byte_mask_i |-> ##2 data_pins_oe_n_o[0];
    endproperty
    a_lo_mask: assert property (p_lo_mask)
        else $error("low lane driven under mask");
    property p_hi_mask;
        high_byte_mask_i |-> ##2 data_pins_oe_n_o[1];
    endproperty
    a_hi_mask: assert property (p_hi_mask)
        else $error("high lane driven under mask");
    property p_bank_open;
        act |-> ##2 bank_open_o[$past({bank_pick_hi_i, bank_pick_lo_i}, 2)];
    endproperty
    a_bank_open: assert property (p_bank_open)
        else $error("activated bank not open");
    property p_deselect;
        chip_select_n_i || !clock_gate_i |-> ##2 $stable(bank_open_o);
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("deselected command changed banks");
    property p_no_stall;
        !write_stall_o;
    endproperty
    a_no_stall: assert property (p_no_stall)
        else $error("write word lost");
endmodule
bind sdram_command_access sdram_access_sva u_sva (
    .mclk_i, .rst_n_i, .chip_select_n_i, .row_strobe_n_i,
    .column_strobe_n_i, .write_strobe_n_i, .clock_gate_i, .addr_i,
    .bank_pick_lo_i, .bank_pick_hi_i, .low_byte_mask_i,
    .high_byte_mask_i, .data_pins_oe_n_o, .bank_open_o, .write_stall_o
);
`default_nettype wire

// *** test/sdram_ctrl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module sdram_ctrl_model (
    // Clock
    input  wire logic        mclk_i,
    // Command pins
    output var logic         cs_n_o,
    output var logic [2:0]   cmd_o,
    output var logic         gate_o,
    // Address, masks and data
    output var logic [11:0]  addr_o,
    output var logic [1:0]   bank_o,
    output var logic [1:0]   mask_o,
    output var logic [15:0]  data_o
);
    // Quiet bus, clock gate high from time zero
    initial begin
        cs_n_o = 1'b1;
        cmd_o  = 3'h7;
        gate_o = 1'b1;
        addr_o = 12'h000;
        bank_o = 2'h0;
        mask_o = 2'h0;
        data_o = 16'h0000;
    end
    // One slot: change after the edge, hold a cycle
    task automatic cyc(
        input logic [3:0]  c,  // Select and strobes
        input logic [1:0]  b,  // Bank
        input logic [11:0] a,  // Row, column or mode
        input logic [15:0] d,  // Write word
        input logic        dv, // Word valid
        input logic [1:0]  m   // Lane masks
    );
        @(posedge mclk_i);
        cs_n_o <= c[3];
        cmd_o  <= c[2:0];
        bank_o <= b;
        addr_o <= a;
        mask_o <= m;
        // Released pins show the inverse of their previous value
        data_o <= dv ? d : ~data_o;
    endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [3:0] MD  = {1'b0, sdram_access_pkg::CMD_MODE};
    localparam logic [3:0] ACT = {1'b0, sdram_access_pkg::CMD_ACT};
    localparam logic [3:0] RD  = {1'b0, sdram_access_pkg::CMD_RD};
    localparam logic [3:0] WR  = {1'b0, sdram_access_pkg::CMD_WR};
    localparam logic [3:0] NOP = 4'h7;
    // One expected read word
    typedef struct packed {
        logic [1:0]  oe; // Lane enables, low drives
        logic [15:0] d;  // Word
        logic        dc; // Word not compared
    } note_t;
    logic        mclk_i;
    logic        rst_n_i;
    logic        cs_n;
    logic [2:0]  cmd;
    logic        gate;
    logic [11:0] addr;
    logic [1:0]  bank;
    logic [1:0]  mask;
    logic [15:0] dq_in;
    logic [15:0] dq_out;
    logic [1:0]  oe_n;
    logic [3:0]  bank_open;
    logic        stall;
    note_t       q[$];                 // Expected words
    note_t       e;                    // Note taken off
    logic [15:0] mem [0:511];          // Bank one, row zero
    logic [31:0] seed = 32'h0000_8F95; // Random state
    int          error_cnt = 0;
    int          checked = 0;
    // Clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    sdram_ctrl_model ctrl (.mclk_i(mclk_i), .cs_n_o(cs_n), .cmd_o(cmd),
        .gate_o(gate), .addr_o(addr), .bank_o(bank), .mask_o(mask),
        .data_o(dq_in));
    sdram_command_access dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .chip_select_n_i(cs_n), .row_strobe_n_i(cmd[2]),
        .column_strobe_n_i(cmd[1]), .write_strobe_n_i(cmd[0]),
        .clock_gate_i(gate), .addr_i(addr), .bank_pick_lo_i(bank[0]),
        .bank_pick_hi_i(bank[1]), .low_byte_mask_i(mask[0]),
        .high_byte_mask_i(mask[1]), .data_pins_i(dq_in),
        .data_pins_o(dq_out), .data_pins_oe_n_o(oe_n),
        .bank_open_o(bank_open), .write_stall_o(stall));
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Verdict
    task automatic tally_and_finish();
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Xorshift words
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // Column of burst word k
    function automatic logic [8:0] bcol(input logic [8:0] c, input int k,
                                        input int n, input logic il);
        if (il) return c ^ k[8:0];
        return (c & ~(n[8:0] - 9'h1)) | ((c + k[8:0]) & (n[8:0] - 9'h1));
    endfunction
    task automatic idle(input int n);
        repeat (n) ctrl.cyc(NOP, 2'h1, 12'h000, 16'h0000, 1'b0, 2'h0);
    endtask
    // Command with no data
    task automatic op(input logic [3:0] c, input logic [1:0] b,
                      input logic [11:0] a);
        ctrl.cyc(c, b, a, 16'h0000, 1'b0, 2'h0);
    endtask
    // BL4 write, lane mask m on the first word
    task automatic wr(input logic [8:0] c, input int n, input logic [1:0] m);
        logic [15:0] w;
        logic [8:0]  a;
        for (int k = 0; k < n; k++) begin
            w = rnd();
            a = bcol(c, k, 4, 1'b0);
            ctrl.cyc(k == 0 ? WR : NOP, 2'h1, {3'h0, c}, w, 1'b1,
                     k == 0 ? m : 2'h0);
            if (!m[0] || k > 0) mem[a][7:0] = w[7:0];
            if (!m[1] || k > 0) mem[a][15:8] = w[15:8];
        end
    endtask
    // Note n words, then issue the read
    task automatic rd(input logic [8:0] c, input int len, input int n,
                      input logic il);
        note_t x;
        for (int k = 0; k < n; k++) begin
            x.oe = 2'h0;
            x.d  = mem[bcol(c, k, len, il)];
            x.dc = 1'b0;
            q.push_back(x);
        end
        op(RD, 2'h1, {3'h0, c});
    endtask
    // Take the oldest note whenever a lane drives
    always @(posedge mclk_i) begin
        if (rst_n_i && oe_n !== 2'h3) begin
            if (q.size() == 0) begin
                chk({14'h0, oe_n}, 16'h0003);
            end else begin
                e = q.pop_front();
                chk({14'h0, oe_n}, {14'h0, e.oe});
                if (!e.dc) chk(dq_out & {{8{~e.oe[1]}}, {8{~e.oe[0]}}},
                    e.d & {{8{~e.oe[1]}}, {8{~e.oe[0]}}});
            end
        end
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge mclk_i);
        error_cnt++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        op(MD, 2'h0, 12'h022);
        idle(2);
        op(ACT, 2'h1, 12'h000);
        idle(2);
        op(ACT, 2'h3, 12'h000);
        op({1'b1, ACT[2:0]}, 2'h2, 12'h000);
        idle(3);
        chk({12'h000, bank_open}, 16'h000A);
        wr(9'h00C, 4, 2'h0);
        wr(9'h008, 4, 2'h0);
        ctrl.cyc(NOP, 2'h1, 12'h000, rnd(), 1'b1, 2'h0);
        wr(9'h010, 2, 2'h0);
        wr(9'h00A, 4, 2'h1);
        idle(6);
        rd(9'h010, 4, 2, 1'b0);
        idle(1);
        rd(9'h00C, 4, 2, 1'b0);
        idle(1);
        rd(9'h008, 4, 4, 1'b0);
        idle(6);
        wr(9'h014, 4, 2'h0);
        wr(9'h014, 2, 2'h0);
        // Read cuts the write; three read words, last two masked
        rd(9'h00C, 4, 1, 1'b0);
        repeat (2) ctrl.cyc(NOP, 2'h1, 12'h000, 16'h0000, 1'b0,
                            2'h3);
        wr(9'h018, 4, 2'h0);
        // Single-word writes: the second word is dropped
        op(MD, 2'h0, 12'h222);
        idle(2);
        wr(9'h018, 1, 2'h0);
        ctrl.cyc(NOP, 2'h1, 12'h000, rnd(), 1'b1, 2'h0);
        idle(3);
        // Reads on back-to-back cycles, then the whole cut burst
        rd(9'h018, 4, 1, 1'b0);
        rd(9'h014, 4, 4, 1'b0);
        idle(3);
        rd(9'h018, 4, 4, 1'b0);
        idle(6);
        op({1'b1, RD[2:0]}, 2'h1, 12'h008);
        idle(4);
        for (int i = 0; i < 4; i++) begin
            op(MD, 2'h0, 12'h020 | i[11:0]);
            idle(2);
            rd(9'h009, 1 << i, 1 << i, 1'b0);
            idle(10);
        end
        op(MD, 2'h0, 12'h03A);
        idle(2);
        rd(9'h009, 4, 4, 1'b1);
        q[q.size() - 1].oe = 2'h2;
        idle(3);
        ctrl.cyc(NOP, 2'h1, 12'h000, 16'h0000, 1'b0, 2'h2);
        idle(8);
        op(MD, 2'h0, 12'h027);
        idle(2);
        rd(9'h000, 512, 3, 1'b0);
        foreach (q[i]) q[i].dc = 1'b1;
        idle(2);
        op({1'b0, sdram_access_pkg::CMD_STOP}, 2'h1, 12'h000);
        idle(6);
        op({1'b0, sdram_access_pkg::CMD_PRE}, 2'h3, 12'h000);
        idle(3);
        chk({12'h000, bank_open}, 16'h0002);
        op({1'b0, sdram_access_pkg::CMD_PRE}, 2'h0, 12'h400);
        idle(3);
        chk({12'h000, bank_open}, 16'h0000);
        chk(16'(q.size()), 16'h0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
